// ### rtl/wd_sup_pkg.sv
package wd_sup_pkg;
	// ==================== timing
	localparam int CLK_NS     = 40;
	localparam int TICK_NS    = 1000000;
	localparam int TICK_CYC   = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int QUIET_MIN  = 30;
	localparam int QUIET_TICKS = QUIET_MIN * 60 * 1000;
	localparam int QUIET_W    = 21;
	localparam int TMO_W      = 16;

	// ==================== register offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_TIMEOUT = 8'h04;
	localparam logic [7:0] OFF_COUNT   = 8'h08;
	localparam logic [7:0] OFF_EXPSTAT = 8'h0c;
	localparam logic [7:0] OFF_MGMT    = 8'h10;
	localparam logic [7:0] OFF_IRQSTAT = 8'h14;
	localparam logic [7:0] OFF_IRQCLR  = 8'h18;
	localparam logic [7:0] OFF_IRQEN   = 8'h1c;
	localparam logic [7:0] OFF_LOGDATA = 8'h20;
	localparam logic [7:0] OFF_LOGIDX  = 8'h24;

	// ==================== field positions
	localparam int CTRL_EN   = 0;
	localparam int CTRL_LOG  = 1;
	localparam int CTRL_USE  = 4;
	localparam int CTRL_ACT  = 8;
	localparam int MGMT_HOLD = 4;
	localparam int MGMT_LAMP = 5;
	localparam int IRQ_W     = 4;
	localparam int IRQ_RST   = 0;
	localparam int IRQ_GIVEUP = 1;
	localparam int IRQ_EXP   = 2;
	localparam int IRQ_QUIET = 3;
	localparam int LOGIDX_WP = 8;

	// ==================== encodings
	localparam logic [2:0] USE_BOOT   = 3'h1;
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_HARD   = 2'h1;
	localparam logic [1:0] ACT_OFF    = 2'h2;
	localparam logic [1:0] ACT_CYCLE  = 2'h3;
	localparam logic [1:0] FAIL_CPU   = 2'h0;
	localparam logic [1:0] FAIL_STACK = 2'h1;
	localparam logic [1:0] FAIL_HWSUB = 2'h2;
	localparam logic [1:0] FAIL_FWSUB = 2'h3;
	localparam logic [1:0] RESTART_LIMIT = 2'h3;
	localparam logic [3:0] LOG_RESTART = 4'h1;
	localparam logic [3:0] LOG_EXPIRE  = 4'h2;
	localparam int LOG_W = 16;
	localparam int LOG_D = 8;

	typedef enum logic [1:0] {
		HT_IDLE    = 2'b00,
		HT_RUN     = 2'b01,
		HT_EXPIRED = 2'b11
	} host_state_t;
endpackage

// ### rtl/ms_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module ms_tick_gen #(
	parameter int DIV = 25000
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// tick
	output var  logic tick_ff
);
	logic [$clog2(DIV)-1:0] cnt_ff;
	logic [$clog2(DIV)-1:0] nxt_cnt;
	logic                   nxt_tick;

	always_comb begin
		nxt_tick = (cnt_ff == $bits(cnt_ff)'(DIV - 1));
		nxt_cnt  = nxt_tick ? '0 : cnt_ff + 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end
endmodule // ms_tick_gen
`default_nettype wire

// ### rtl/wd_event_mem.sv
`timescale 1ns/100ps
`default_nettype none
module wd_event_mem #(
	parameter int W = 16,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// write port
	input  wire logic                 we,
	input  wire logic [$clog2(D)-1:0] waddr,
	input  wire logic [W-1:0]         wdata,
	// read port
	input  wire logic [$clog2(D)-1:0] raddr,
	output var  logic [W-1:0]         rdata_ff
);
	logic [W-1:0] mem [D];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem[raddr];
		end
	end
endmodule // wd_event_mem
`default_nettype wire

// ### rtl/mgmt_wd_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module mgmt_wd_supervisor #(
	parameter int TICK_DIV = wd_sup_pkg::TICK_CYC,
	parameter int QUIET    = wd_sup_pkg::QUIET_TICKS
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	// failure reports
	input  wire logic        fail_valid,
	input  wire logic [1:0]  fail_kind,
	input  wire logic [3:0]  fail_mask,
	input  wire logic        sys_reset_done,
	// controller recovery
	output var  logic        cpu_restart,
	output var  logic        stack_restart,
	output var  logic [3:0]  hw_sub_restart,
	output var  logic [3:0]  fw_sub_restart,
	output var  logic        bootloader_hold,
	output var  logic        degraded_lamp,
	// host power control
	output var  logic        host_hard_reset,
	output var  logic        host_power_off,
	output var  logic        host_power_cycle,
	// interrupt
	output var  logic        irq
);
	localparam int LA = $clog2(wd_sup_pkg::LOG_D);
	localparam int QW = wd_sup_pkg::QUIET_W;
	localparam int TW = wd_sup_pkg::TMO_W;

	function automatic logic hit(input logic [31:0] a, input logic [7:0] o);
		return (a[31:8] == 24'h000000) && (a[7:0] == o);
	endfunction

	// ==================== state
	logic        tick;
	logic [31:0] rd_val;
	logic        wr_ff, nxt_wr;
	logic [31:0] waddr_ff, nxt_waddr;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic        rdy_ff;
	logic        resp_ff;
	logic [11:0] ctrl_ff, nxt_ctrl;
	logic [wd_sup_pkg::TMO_W-1:0] tmo_ff, nxt_tmo;
	wd_sup_pkg::host_state_t hst_ff, nxt_hst;
	logic        exp_ff, nxt_exp;
	logic [2:0]  exp_use_ff, nxt_exp_use;
	logic [1:0]  cnt_ff, nxt_cnt;
	logic [wd_sup_pkg::QUIET_W-1:0] quiet_ff, nxt_quiet;
	logic        cpu_ff, nxt_cpu, stk_ff, nxt_stk;
	logic [3:0]  hws_ff, nxt_hws, fws_ff, nxt_fws;
	logic        hold_ff, nxt_hold, lamp_ff, nxt_lamp;
	logic        hrst_ff, nxt_hrst, poff_ff, nxt_poff;
	logic        pcyc_ff, nxt_pcyc;
	logic [wd_sup_pkg::IRQ_W-1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
	logic        irq_ff, nxt_irq;
	logic        prst_ff, nxt_prst, pexp_ff, nxt_pexp;
	logic [11:0] rinfo_ff, nxt_rinfo, einfo_ff, nxt_einfo;
	logic [LA-1:0] lwp_ff, nxt_lwp, lrp_ff, nxt_lrp;
	logic        log_we;
	logic [wd_sup_pkg::LOG_W-1:0] log_wd, log_rd;
	logic        restarted, expire, quiet_hit, gave_up;

	ms_tick_gen #(.DIV(TICK_DIV)) u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick_ff (tick)
	);

	wd_event_mem #(.W(wd_sup_pkg::LOG_W), .D(wd_sup_pkg::LOG_D)) u_log (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.we       (log_we),
		.waddr    (lwp_ff),
		.wdata    (log_wd),
		.raddr    (lrp_ff),
		.rdata_ff (log_rd)
	);

	// ==================== read mux
	always_comb begin
		rd_val = 32'h00000000;
		if (hit(haddr, wd_sup_pkg::OFF_CTRL))
			rd_val = {20'h00000, ctrl_ff};
		if (hit(haddr, wd_sup_pkg::OFF_TIMEOUT) || hit(haddr, wd_sup_pkg::OFF_COUNT))
			rd_val = {16'h0000, tmo_ff};
		if (hit(haddr, wd_sup_pkg::OFF_EXPSTAT))
			rd_val = {24'h000000, exp_use_ff, 4'h0, exp_ff};
		if (hit(haddr, wd_sup_pkg::OFF_MGMT))
			rd_val = {26'h0000000, lamp_ff, hold_ff, 2'h0, cnt_ff};
		if (hit(haddr, wd_sup_pkg::OFF_IRQSTAT))
			rd_val = {28'h0000000, ist_ff};
		if (hit(haddr, wd_sup_pkg::OFF_IRQEN))
			rd_val = {28'h0000000, ien_ff};
		if (hit(haddr, wd_sup_pkg::OFF_LOGDATA))
			rd_val = {16'h0000, log_rd};
		if (hit(haddr, wd_sup_pkg::OFF_LOGIDX))
			rd_val = {{(32 - wd_sup_pkg::LOGIDX_WP - LA){1'b0}}, lwp_ff,
				{(wd_sup_pkg::LOGIDX_WP - LA){1'b0}}, lrp_ff};
	end

	// ==================== next state
	always_comb begin
		nxt_wr     = wr_ff;
		nxt_waddr  = waddr_ff;
		nxt_hrdata = hrdata_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_tmo    = tmo_ff;
		nxt_hst    = hst_ff;
		nxt_exp    = exp_ff;
		nxt_exp_use = exp_use_ff;
		nxt_cnt    = cnt_ff;
		nxt_quiet  = quiet_ff;
		nxt_cpu    = 1'b0;
		nxt_stk    = 1'b0;
		nxt_hws    = 4'h0;
		nxt_fws    = 4'h0;
		nxt_hold   = hold_ff;
		nxt_lamp   = lamp_ff;
		nxt_hrst   = 1'b0;
		nxt_poff   = 1'b0;
		nxt_pcyc   = 1'b0;
		nxt_ist    = ist_ff;
		nxt_ien    = ien_ff;
		nxt_prst   = prst_ff;
		nxt_pexp   = pexp_ff;
		nxt_rinfo  = rinfo_ff;
		nxt_einfo  = einfo_ff;
		nxt_lwp    = lwp_ff;
		nxt_lrp    = lrp_ff;
		log_we     = 1'b0;
		log_wd     = {wd_sup_pkg::LOG_RESTART, rinfo_ff};
		restarted  = 1'b0;
		expire     = 1'b0;
		gave_up    = 1'b0;
		quiet_hit  = 1'b0;

		// bus: address phase sampled, data phase applied
		if (hready) begin
			nxt_wr = hsel && htrans[1] && hwrite;
			nxt_waddr = haddr;
			if (hsel && htrans[1] && !hwrite)
				nxt_hrdata = rd_val;
		end
		if (wr_ff) begin
			if (hit(waddr_ff, wd_sup_pkg::OFF_CTRL)) begin
				nxt_ctrl = hwdata[11:0];
				if (!hwdata[wd_sup_pkg::CTRL_EN])
					nxt_hst = wd_sup_pkg::HT_IDLE;
			end
			if (hit(waddr_ff, wd_sup_pkg::OFF_TIMEOUT)) begin
				nxt_tmo = hwdata[wd_sup_pkg::TMO_W-1:0];
				if (ctrl_ff[wd_sup_pkg::CTRL_EN])
					nxt_hst = wd_sup_pkg::HT_RUN;
			end
			if (hit(waddr_ff, wd_sup_pkg::OFF_EXPSTAT) && hwdata[0])
				nxt_exp = 1'b0;
			if (hit(waddr_ff, wd_sup_pkg::OFF_IRQCLR))
				nxt_ist = ist_ff & ~hwdata[wd_sup_pkg::IRQ_W-1:0];
			if (hit(waddr_ff, wd_sup_pkg::OFF_IRQEN))
				nxt_ien = hwdata[wd_sup_pkg::IRQ_W-1:0];
			if (hit(waddr_ff, wd_sup_pkg::OFF_LOGIDX))
				nxt_lrp = hwdata[LA-1:0];
		end

		// controller restart supervision
		if (fail_valid) begin
			case (fail_kind)
				wd_sup_pkg::FAIL_HWSUB: nxt_hws = fail_mask;
				wd_sup_pkg::FAIL_FWSUB: nxt_fws = fail_mask;
				default: begin
					if (cnt_ff == wd_sup_pkg::RESTART_LIMIT || hold_ff) begin
						nxt_hold = 1'b1;
						gave_up  = !hold_ff;
					end else begin
						restarted = 1'b1;
						nxt_cnt   = cnt_ff + 2'h1;
						nxt_cpu   = (fail_kind == wd_sup_pkg::FAIL_CPU);
						nxt_stk   = (fail_kind == wd_sup_pkg::FAIL_STACK);
					end
				end
			endcase
		end
		if (restarted) begin
			nxt_quiet = '0;
			nxt_lamp  = 1'b1;
			nxt_prst  = 1'b1;
			nxt_rinfo = {2'h0, fail_kind, 6'h00, nxt_cnt};
		end else if (sys_reset_done) begin
			nxt_lamp = 1'b0;
		end
		if (!restarted && tick) begin
			if (quiet_ff > QW'(QUIET)) begin
				quiet_hit = (cnt_ff != 2'h0);
				nxt_cnt   = 2'h0;
			end else begin
				nxt_quiet = quiet_ff + 1'b1;
			end
		end

		// host-facing timer
		case (hst_ff)
			wd_sup_pkg::HT_RUN: begin
				if (tick && nxt_hst == wd_sup_pkg::HT_RUN) begin
					if (tmo_ff <= TW'(1)) begin
						expire  = 1'b1;
						nxt_tmo = '0;
						nxt_hst = wd_sup_pkg::HT_EXPIRED;
					end else begin
						nxt_tmo = tmo_ff - 1'b1;
					end
				end
			end
			wd_sup_pkg::HT_IDLE, wd_sup_pkg::HT_EXPIRED: ;
			default: nxt_hst = wd_sup_pkg::HT_IDLE;
		endcase
		if (expire) begin
			nxt_exp     = 1'b1;
			nxt_exp_use = ctrl_ff[wd_sup_pkg::CTRL_USE +: 3];
			if (ctrl_ff[wd_sup_pkg::CTRL_USE +: 3] == wd_sup_pkg::USE_BOOT) begin
				nxt_hrst = 1'b1;
				if (ctrl_ff[wd_sup_pkg::CTRL_LOG]) begin
					nxt_pexp  = 1'b1;
					nxt_einfo = {1'b0, wd_sup_pkg::USE_BOOT, 8'h00};
				end
			end else begin
				case (ctrl_ff[wd_sup_pkg::CTRL_ACT +: 2])
					wd_sup_pkg::ACT_HARD:  nxt_hrst = 1'b1;
					wd_sup_pkg::ACT_OFF:   nxt_poff = 1'b1;
					wd_sup_pkg::ACT_CYCLE: nxt_pcyc = 1'b1;
					default: ;
				endcase
				if (ctrl_ff[wd_sup_pkg::CTRL_LOG]) begin
					nxt_pexp  = 1'b1;
					nxt_einfo = {1'b0, ctrl_ff[wd_sup_pkg::CTRL_USE +: 3], 8'h00};
				end
			end
		end

		// event log, restart first
		if (prst_ff) begin
			log_we   = 1'b1;
			nxt_prst = restarted;
			nxt_lwp  = lwp_ff + 1'b1;
		end else if (pexp_ff) begin
			log_we   = 1'b1;
			log_wd   = {wd_sup_pkg::LOG_EXPIRE, einfo_ff};
			nxt_pexp = expire && ctrl_ff[wd_sup_pkg::CTRL_LOG];
			nxt_lwp  = lwp_ff + 1'b1;
		end

		// sticky status, set wins over clear
		if (restarted)
			nxt_ist[wd_sup_pkg::IRQ_RST] = 1'b1;
		if (gave_up)
			nxt_ist[wd_sup_pkg::IRQ_GIVEUP] = 1'b1;
		if (expire)
			nxt_ist[wd_sup_pkg::IRQ_EXP] = 1'b1;
		if (quiet_hit)
			nxt_ist[wd_sup_pkg::IRQ_QUIET] = 1'b1;
		nxt_irq = |(nxt_ist & nxt_ien);
	end

	// ==================== registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff      <= 1'b0;
			waddr_ff   <= 32'h00000000;
			hrdata_ff  <= 32'h00000000;
			rdy_ff     <= 1'b0;
			resp_ff    <= 1'b0;
			ctrl_ff    <= 12'h000;
			tmo_ff     <= '0;
			hst_ff     <= wd_sup_pkg::HT_IDLE;
			exp_ff     <= 1'b0;
			exp_use_ff <= 3'h0;
			cnt_ff     <= 2'h0;
			quiet_ff   <= '0;
			cpu_ff     <= 1'b0;
			stk_ff     <= 1'b0;
			hws_ff     <= 4'h0;
			fws_ff     <= 4'h0;
			hold_ff    <= 1'b0;
			lamp_ff    <= 1'b0;
			hrst_ff    <= 1'b0;
			poff_ff    <= 1'b0;
			pcyc_ff    <= 1'b0;
			ist_ff     <= '0;
			ien_ff     <= '0;
			irq_ff     <= 1'b0;
			prst_ff    <= 1'b0;
			pexp_ff    <= 1'b0;
			rinfo_ff   <= 12'h000;
			einfo_ff   <= 12'h000;
			lwp_ff     <= '0;
			lrp_ff     <= '0;
		end else begin
			wr_ff      <= nxt_wr;
			waddr_ff   <= nxt_waddr;
			hrdata_ff  <= nxt_hrdata;
			rdy_ff     <= 1'b1;
			resp_ff    <= 1'b0;
			ctrl_ff    <= nxt_ctrl;
			tmo_ff     <= nxt_tmo;
			hst_ff     <= nxt_hst;
			exp_ff     <= nxt_exp;
			exp_use_ff <= nxt_exp_use;
			cnt_ff     <= nxt_cnt;
			quiet_ff   <= nxt_quiet;
			cpu_ff     <= nxt_cpu;
			stk_ff     <= nxt_stk;
			hws_ff     <= nxt_hws;
			fws_ff     <= nxt_fws;
			hold_ff    <= nxt_hold;
			lamp_ff    <= nxt_lamp;
			hrst_ff    <= nxt_hrst;
			poff_ff    <= nxt_poff;
			pcyc_ff    <= nxt_pcyc;
			ist_ff     <= nxt_ist;
			ien_ff     <= nxt_ien;
			irq_ff     <= nxt_irq;
			prst_ff    <= nxt_prst;
			pexp_ff    <= nxt_pexp;
			rinfo_ff   <= nxt_rinfo;
			einfo_ff   <= nxt_einfo;
			lwp_ff     <= nxt_lwp;
			lrp_ff     <= nxt_lrp;
		end
	end

	assign hrdata           = hrdata_ff;
	assign hreadyout        = rdy_ff;
	assign hresp            = resp_ff;
	assign cpu_restart      = cpu_ff;
	assign stack_restart    = stk_ff;
	assign hw_sub_restart   = hws_ff;
	assign fw_sub_restart   = fws_ff;
	assign bootloader_hold  = hold_ff;
	assign degraded_lamp    = lamp_ff;
	assign host_hard_reset  = hrst_ff;
	assign host_power_off   = poff_ff;
	assign host_power_cycle = pcyc_ff;
	assign irq              = irq_ff;

	// ==================== assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	restart_limit_a: assert property (
		$rose(hold_ff) |-> $past(cnt_ff) == wd_sup_pkg::RESTART_LIMIT)
		else $error("gave up below restart limit");
	limit_hold_a: assert property (
		fail_valid && !fail_kind[1] && cnt_ff == wd_sup_pkg::RESTART_LIMIT
		|=> hold_ff && !cpu_ff && !stk_ff) else $error("restart beyond limit");
	quiet_clear_a: assert property (
		tick && !fail_valid && quiet_ff > QW'(QUIET)
		|=> cnt_ff == 2'h0) else $error("count not cleared after quiet");
	restart_log_a: assert property (
		$rose(cpu_ff) || $rose(stk_ff)
		|-> ##[0:2] (log_we && log_wd[15:12] == wd_sup_pkg::LOG_RESTART))
		else $error("restart not logged");
	lamp_on_a: assert property (
		(cpu_ff || stk_ff) |-> lamp_ff) else $error("lamp not degraded");
	sub_restart_a: assert property (
		fail_valid && fail_kind == wd_sup_pkg::FAIL_HWSUB
		|=> hws_ff == $past(fail_mask) && !cpu_ff) else $error("wrong recovery");
	boot_log_a: assert property (
		$rose(exp_ff) && exp_use_ff == wd_sup_pkg::USE_BOOT && ctrl_ff[wd_sup_pkg::CTRL_LOG]
		|-> ##[0:3] (log_we && log_wd[15:12] == wd_sup_pkg::LOG_EXPIRE))
		else $error("boot expiry not logged");
	boot_reset_a: assert property (
		$rose(exp_ff) && exp_use_ff == wd_sup_pkg::USE_BOOT |-> hrst_ff)
		else $error("no host reset on boot expiry");
	lamp_cause_a: assert property (
		$rose(lamp_ff) |-> $past(fail_valid) && !$past(fail_kind[1]))
		else $error("lamp changed without restart");
	power_off_a: assert property (
		expire && ctrl_ff[wd_sup_pkg::CTRL_USE +: 3] != wd_sup_pkg::USE_BOOT
		&& ctrl_ff[wd_sup_pkg::CTRL_ACT +: 2] == wd_sup_pkg::ACT_OFF
		|=> poff_ff && !hrst_ff) else $error("power off not taken");
	quiet_restart_a: assert property (
		cpu_ff || stk_ff |-> quiet_ff == '0) else $error("quiet timer not restarted");

	restart_c: cover property ($rose(cpu_ff));
	giveup_c: cover property ($rose(hold_ff));
	boot_exp_c: cover property ($rose(hrst_ff) ##1 log_we);
endmodule // mgmt_wd_supervisor
`default_nettype wire

// ### test/host_fw_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_fw_model (
	// clock
	input  wire logic        hclk,
	// ahb-lite master
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	// ==================== firmware state
	logic [31:0] last_post_code = 32'h0000_00a5;
	logic [31:0] fw_log_entry   = 32'h0000_0000;

	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'b010;
		hwdata = 32'h0000_0000;
	end

	// ==================== bus cycles
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize  <= 3'b010;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		xfer(a, 1'b0, 32'h0000_0000, r);
	endtask

	// ==================== boot-progress use
	task automatic arm_boot(input logic [1:0] act, input logic [15:0] t);
		wr(wd_sup_pkg::OFF_CTRL, {22'h00_0000, act, 8'h13});
		wr(wd_sup_pkg::OFF_TIMEOUT, {16'h0000, t});
	endtask

	// before option scan or password prompt
	task automatic disarm();
		wr(wd_sup_pkg::OFF_CTRL, 32'h0000_0000);
	endtask

	task automatic read_expiry(output logic [31:0] st);
		rd(wd_sup_pkg::OFF_EXPSTAT, st);
		if (st[0] === 1'b1 && st[7:5] === wd_sup_pkg::USE_BOOT)
			fw_log_entry = last_post_code;
	endtask
endmodule // host_fw_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int TICK_DIV = 4;
	localparam int QUIET    = 10;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fail_valid, sys_reset_done;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, fail_kind;
	logic [2:0]  hsize;
	logic [3:0]  fail_mask, hw_sub_restart, fw_sub_restart;
	logic        cpu_restart, stack_restart, bootloader_hold, degraded_lamp;
	logic        host_hard_reset, host_power_off, host_power_cycle, irq;
	int          failures = 0;
	int          check_count = 0;

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	host_fw_model i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata));

	mgmt_wd_supervisor #(.TICK_DIV(TICK_DIV), .QUIET(QUIET)) i_dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .fail_valid(fail_valid), .fail_kind(fail_kind),
		.fail_mask(fail_mask), .sys_reset_done(sys_reset_done), .cpu_restart(cpu_restart),
		.stack_restart(stack_restart), .hw_sub_restart(hw_sub_restart),
		.fw_sub_restart(fw_sub_restart), .bootloader_hold(bootloader_hold),
		.degraded_lamp(degraded_lamp), .host_hard_reset(host_hard_reset),
		.host_power_off(host_power_off), .host_power_cycle(host_power_cycle), .irq(irq));

	// ==================== helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		i_host.rd(a, r);
		chk(r & m, e);
	endtask

	task automatic log_chk(input logic [2:0] idx, input logic [31:0] m, input logic [31:0] e);
		i_host.wr(wd_sup_pkg::OFF_LOGIDX, {29'h0, idx});
		@(posedge hclk);
		rd_chk(wd_sup_pkg::OFF_LOGDATA, m, e);
	endtask

	// result vector: hold, lamp, cpu, stack, hw[3:0], fw[3:0]
	task automatic fail(input logic [1:0] k, input logic [3:0] m, input logic [11:0] e);
		fail_valid <= 1'b1;
		fail_kind  <= k;
		fail_mask  <= m;
		@(posedge hclk);
		fail_valid <= 1'b0;
		@(posedge hclk);
		chk({20'h0, bootloader_hold, degraded_lamp, cpu_restart, stack_restart,
			hw_sub_restart, fw_sub_restart}, {20'h0, e});
	endtask

	task automatic wait_host(input logic [2:0] e);
		logic [2:0] v;
		v = 3'b000;
		for (int i = 0; i < 200 && v === 3'b000; i++) begin
			@(posedge hclk);
			v = {host_hard_reset, host_power_off, host_power_cycle};
		end
		chk({29'h0, v}, {29'h0, e});
	endtask

	task automatic test_done();
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==================== scenarios
	task automatic t_reset();
		chk({27'h0, hresp, bootloader_hold, degraded_lamp, irq, hreadyout}, 32'h1);
		rd_chk(wd_sup_pkg::OFF_MGMT, 32'hffff_ffff, 32'h0);
		i_host.wr(8'h30, 32'hffff_ffff);
		rd_chk(8'h30, 32'hffff_ffff, 32'h0);
		i_host.wr(wd_sup_pkg::OFF_IRQEN, 32'hf);
		rd_chk(wd_sup_pkg::OFF_IRQEN, 32'hffff_ffff, 32'hf);
	endtask

	task automatic t_kinds();
		fail(wd_sup_pkg::FAIL_HWSUB, 4'ha, 12'h0a0);
		fail(wd_sup_pkg::FAIL_FWSUB, 4'h5, 12'h005);
		fail(wd_sup_pkg::FAIL_STACK, 4'h0, 12'h500);
		rd_chk(wd_sup_pkg::OFF_MGMT, 32'h3, 32'h1);
		log_chk(3'h0, 32'hf300, 32'h1100);
		repeat (64) @(posedge hclk);
		rd_chk(wd_sup_pkg::OFF_MGMT, 32'h3, 32'h0);
		rd_chk(wd_sup_pkg::OFF_IRQSTAT, 32'h9, 32'h9);
		chk({31'h0, irq}, 32'h1);
		i_host.wr(wd_sup_pkg::OFF_IRQEN, 32'h0);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		i_host.wr(wd_sup_pkg::OFF_IRQEN, 32'hf);
		i_host.wr(wd_sup_pkg::OFF_IRQCLR, 32'hf);
		repeat (2) @(posedge hclk);
		rd_chk(wd_sup_pkg::OFF_IRQSTAT, 32'hf, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_limit();
		repeat (3) fail(wd_sup_pkg::FAIL_CPU, 4'h0, 12'h600);
		fail(wd_sup_pkg::FAIL_CPU, 4'h0, 12'hc00);
		rd_chk(wd_sup_pkg::OFF_MGMT, 32'h13, 32'h13);
		log_chk(3'h3, 32'hf300, 32'h1000);
		sys_reset_done <= 1'b1;
		@(posedge hclk);
		sys_reset_done <= 1'b0;
		@(posedge hclk);
		chk({31'h0, degraded_lamp}, 32'h0);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rd_chk(wd_sup_pkg::OFF_MGMT, 32'hffff_ffff, 32'h0);
	endtask

	task automatic t_boot();
		logic [31:0] st;
		fail(wd_sup_pkg::FAIL_STACK, 4'h0, 12'h500);
		i_host.arm_boot(wd_sup_pkg::ACT_OFF, 16'h0003);
		wait_host(3'b100);
		chk({31'h0, degraded_lamp}, 32'h1);
		i_host.read_expiry(st);
		chk(st & 32'hff, 32'h21);
		chk(i_host.fw_log_entry, 32'h0000_00a5);
		chk({31'h0, hresp}, 32'h0);
		i_host.wr(wd_sup_pkg::OFF_EXPSTAT, 32'h1);
		rd_chk(wd_sup_pkg::OFF_EXPSTAT, 32'h1, 32'h0);
		log_chk(3'h1, 32'hf700, 32'h2100);
	endtask

	task automatic t_actions();
		for (int a = 0; a < 4; a++) begin
			i_host.wr(wd_sup_pkg::OFF_CTRL, {22'h0, 2'(a), 8'h01});
			i_host.wr(wd_sup_pkg::OFF_TIMEOUT, 32'h3);
			wait_host(a == 0 ? 3'b000 : 3'(3'b001 << (3 - a)));
		end
	endtask

	task automatic t_disarm();
		i_host.arm_boot(wd_sup_pkg::ACT_HARD, 16'h0005);
		i_host.disarm();
		wait_host(3'b000);
	endtask

	// ==================== main sequence
	initial begin
		hresetn        = 1'b0;
		fail_valid     = 1'b0;
		fail_kind      = 2'h0;
		fail_mask      = 4'h0;
		sys_reset_done = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_kinds();
		t_limit();
		t_boot();
		t_actions();
		t_disarm();
		test_done();
	end

	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		test_done();
	end
endmodule // tb_top
`default_nettype wire
